/* hw/dfm_defs.vh */
`ifndef DFM_DEFS_VH
`define DFM_DEFS_VH

// Fault codes
`define DFM_CODE_NONE        8'h00
`define DFM_CODE_BRAKE_CUR   8'h01
`define DFM_CODE_BRAKE_OVL   8'h02
`define DFM_CODE_OUT_OVC     8'h03
`define DFM_CODE_MOTOR_OVL   8'h04

// Access code default and brake chopper selection
`define DFM_ACCESS_CODE_RST  16'h0065
`define DFM_CHOPPER_SEL_ON   2'h1

// Clock and times
`define DFM_CLK_HZ           100000000
`define DFM_LOCKOUT_BASE_S   2
`define DFM_LOCKOUT_MAX_IDX  3'h6
`define DFM_TRIP_CNT_SAT     3'h6
`define DFM_OK_HOLD_MS       2000
`define DFM_FLASH_MS         250
`define DFM_LOG_DEPTH        4

`endif

/* hw/dfm_edge_sync.v */
`timescale 1ns/1ps
`include "dfm_defs.vh"

module dfm_edge_sync (
    // Clock and reset
    input  wire clock_i,
    input  wire nrst_i,
    // Pin side
    input  wire pin_i,
    // Logic side
    output reg  level_o,
    output reg  rise_o
);

reg meta_reg;
reg sync_reg;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        level_o  <= 1'b0;
        rise_o   <= 1'b0;
    end else begin
        meta_reg <= pin_i;
        sync_reg <= meta_reg;
        level_o  <= sync_reg;
        rise_o   <= sync_reg & ~level_o;
    end
end

endmodule // dfm_edge_sync

/* hw/dfm_timer.v */
`timescale 1ns/1ps
`include "dfm_defs.vh"

module dfm_timer #(
    parameter WIDTH = 36
) (
    // Clock and reset
    input  wire             clock_i,
    input  wire             nrst_i,
    // Control
    input  wire             start_i,
    input  wire             run_i,
    input  wire [WIDTH-1:0] limit_i,
    // Status
    output reg              done_o
);

reg [WIDTH-1:0] count_reg;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        count_reg <= {WIDTH{1'b0}};
        done_o    <= 1'b0;
    end else if (start_i || !run_i) begin
        count_reg <= {WIDTH{1'b0}};
        done_o    <= 1'b0;
    end else if (count_reg >= limit_i) begin
        done_o    <= 1'b1;
    end else begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

endmodule // dfm_timer

/* hw/dfm_fault_manager.v */
`timescale 1ns/1ps
`include "dfm_defs.vh"

// Functional notes
// - Any fault shows its code and opens the run relay by default.
// - Log holds last four faults, newest first, shown first on opening.
// - Stop button or power cycle clears the active fault.
// - New rising edge on forward or reverse enable clears the fault.
// - Fieldbus reset bit written as one clears the active fault.
// - Overcurrent and overload trips ignore resets until lockout elapses.
// - Lockout doubles per trip: 2,4,8,16,32 s, then 64 s.
// - Factory default restore leaves fault log untouched.
// - Log viewable only when access entry equals access code, default 101.
// - Up key steps to older entry; flashing dots show position.
// - Codes: brake current 01, resistor 02, overcurrent 03, overload 04.
// - Brake resistor overload raised only when chopper selection is 1.
// - Motor overload trips after current exceeds rating too long.
// - Decimal points flash while motor current exceeds its rating.
// - Stop-ready shown with no enable and no fault.
// - OK held about two seconds enters or confirms editing.
// - Run relay closes with an enable asserted and no fault.
module dfm_fault_manager #(
    parameter CLK_HZ      = `DFM_CLK_HZ,
    parameter LOCK_BASE_S = `DFM_LOCKOUT_BASE_S,
    parameter OK_HOLD_MS  = `DFM_OK_HOLD_MS,
    parameter FLASH_MS    = `DFM_FLASH_MS,
    parameter OVL_CYCLES  = 1000000
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        nrst_i,
    // Terminal inputs
    input  wire        forward_enable_input_i,
    input  wire        reverse_enable_input_i,
    // Keypad
    input  wire        stop_key_i,
    input  wire        up_key_i,
    input  wire        ok_key_i,
    // Monitors, same clock
    input  wire        brake_current_trip_i,
    input  wire        brake_resistor_overload_i,
    input  wire        out_overcurrent_trip_i,
    input  wire        motor_over_rated_i,
    // Configuration
    input  wire [1:0]  chopper_sel_i,
    input  wire [15:0] access_entry_i,
    input  wire [15:0] access_code_i,
    input  wire        relay_on_fault_i,
    input  wire        defaults_restore_i,
    input  wire        fault_log_view_i,
    // Fieldbus
    input  wire        bus_reset_bit_i,
    // Status
    output reg  [7:0]  fault_code_o,
    output reg         fault_active_o,
    output reg         run_relay_o,
    output reg         stop_ready_indication_o,
    output reg  [7:0]  log_entry_o,
    output reg  [1:0]  log_index_o,
    output reg  [3:0]  log_dots_o,
    output reg         log_view_active_o,
    output reg         overload_dots_o,
    output reg         ok_hold_o,
    output reg         motor_overload_trip_o
);

// ----------------------------------------------------------------
// Derived counts
// ----------------------------------------------------------------
localparam [35:0] LOCK_BASE_CYC = CLK_HZ * LOCK_BASE_S;
localparam [35:0] OK_HOLD_CYC   = (CLK_HZ / 1000) * OK_HOLD_MS;
localparam [35:0] FLASH_CYC     = (CLK_HZ / 1000) * FLASH_MS;
localparam [35:0] OVL_CYC       = OVL_CYCLES;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
wire fwd_level;
wire fwd_rise;
wire rev_level;
wire rev_rise;
wire stop_level;
wire stop_rise;
wire up_level;
wire up_rise;
wire ok_level;
wire bus_level;
wire bus_rise;

dfm_edge_sync u_fwd  (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(forward_enable_input_i),
                      .level_o(fwd_level), .rise_o(fwd_rise));
dfm_edge_sync u_rev  (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(reverse_enable_input_i),
                      .level_o(rev_level), .rise_o(rev_rise));
dfm_edge_sync u_stop (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(stop_key_i),
                      .level_o(stop_level), .rise_o(stop_rise));
dfm_edge_sync u_up   (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(up_key_i),
                      .level_o(up_level), .rise_o(up_rise));
dfm_edge_sync u_ok   (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(ok_key_i),
                      .level_o(ok_level), .rise_o());
dfm_edge_sync u_bus  (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(bus_reset_bit_i),
                      .level_o(bus_level), .rise_o(bus_rise));

// ----------------------------------------------------------------
// Motor overload integration
// ----------------------------------------------------------------
wire ovl_done;

dfm_timer u_ovl_timer (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .start_i (1'b0),
    .run_i   (motor_over_rated_i),
    .limit_i (OVL_CYC),
    .done_o  (ovl_done)
);

// ----------------------------------------------------------------
// Fault detection and priority
// ----------------------------------------------------------------
reg  [7:0] new_code;
wire       res_ovl_en = (chopper_sel_i == `DFM_CHOPPER_SEL_ON);

always @* begin
    new_code = `DFM_CODE_NONE;
    if (brake_current_trip_i)
        new_code = `DFM_CODE_BRAKE_CUR;
    else if (brake_resistor_overload_i && res_ovl_en)
        new_code = `DFM_CODE_BRAKE_OVL;
    else if (out_overcurrent_trip_i)
        new_code = `DFM_CODE_OUT_OVC;
    else if (ovl_done)
        new_code = `DFM_CODE_MOTOR_OVL;
end

wire new_fault  = !fault_active_o && (new_code != `DFM_CODE_NONE);
wire lock_class = (new_code == `DFM_CODE_OUT_OVC) || (new_code == `DFM_CODE_MOTOR_OVL);

// ----------------------------------------------------------------
// Lockout trip counter and delay
// ----------------------------------------------------------------
reg  [2:0]  trip_cnt_reg;
reg         locked_reg;
wire        lock_done;
// Sixth and later trips keep the longest delay
wire [2:0]  shift_idx = (trip_cnt_reg > `DFM_LOCKOUT_MAX_IDX) ? `DFM_LOCKOUT_MAX_IDX
                                                              : trip_cnt_reg;
wire [35:0] lock_limit = LOCK_BASE_CYC << (shift_idx - 3'h1);
wire        lock_start = new_fault && lock_class;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        trip_cnt_reg <= 3'h0;
    end else if (lock_start && trip_cnt_reg != `DFM_TRIP_CNT_SAT) begin
        trip_cnt_reg <= trip_cnt_reg + 3'h1;
    end
end

dfm_timer u_lock_timer (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .start_i (lock_start),
    .run_i   (locked_reg),
    .limit_i (lock_limit),
    .done_o  (lock_done)
);

// ----------------------------------------------------------------
// Active fault and reset requests
// ----------------------------------------------------------------
wire reset_req = stop_rise || fwd_rise || rev_rise || bus_rise;
wire reset_ok  = !locked_reg || lock_done;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        fault_active_o <= 1'b0;
        fault_code_o   <= `DFM_CODE_NONE;
        locked_reg     <= 1'b0;
    end else if (new_fault) begin
        fault_active_o <= 1'b1;
        fault_code_o   <= new_code;
        locked_reg     <= lock_class;
    end else if (fault_active_o && reset_req && reset_ok) begin
        fault_active_o <= 1'b0;
        fault_code_o   <= `DFM_CODE_NONE;
        locked_reg     <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Relay and indications
// ----------------------------------------------------------------
wire enabled = fwd_level || rev_level;
wire blocked = (fault_active_o || new_fault) && relay_on_fault_i;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        run_relay_o             <= 1'b0;
        stop_ready_indication_o <= 1'b0;
        motor_overload_trip_o   <= 1'b0;
    end else begin
        run_relay_o             <= enabled && !blocked;
        stop_ready_indication_o <= !enabled && !fault_active_o;
        motor_overload_trip_o   <= fault_code_o == `DFM_CODE_MOTOR_OVL;
    end
end

// ----------------------------------------------------------------
// Fault log, kept through default restore
// ----------------------------------------------------------------
reg [7:0] log_mem [0:`DFM_LOG_DEPTH-1];
integer   i;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        for (i = 0; i < `DFM_LOG_DEPTH; i = i + 1)
            log_mem[i] <= `DFM_CODE_NONE;
    end else if (new_fault) begin
        for (i = `DFM_LOG_DEPTH-1; i > 0; i = i - 1)
            log_mem[i] <= log_mem[i-1];
        log_mem[0] <= new_code;
    end
end
// defaults_restore_i deliberately has no effect on log_mem
wire unused_defaults = defaults_restore_i;

// ----------------------------------------------------------------
// Log viewer
// ----------------------------------------------------------------
// Flash state, also read by the dots below
reg [35:0] flash_cnt_reg;
reg        flash_reg;

wire unlocked = (access_entry_i == access_code_i);
wire view_en  = fault_log_view_i && unlocked;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        log_view_active_o <= 1'b0;
        log_index_o       <= 2'h0;
        log_entry_o       <= 8'h00;
        log_dots_o        <= 4'h0;
    end else begin
        log_view_active_o <= view_en;
        if (!view_en)
            log_index_o <= 2'h0;
        else if (up_rise && log_index_o != 2'h3)
            log_index_o <= log_index_o + 2'h1;
        log_entry_o <= view_en ? log_mem[log_index_o] : 8'h00;
        log_dots_o  <= (view_en && flash_reg) ? ((4'h2 << log_index_o) - 4'h1)
                                              : 4'h0;
    end
end

// ----------------------------------------------------------------
// Flash timebase and overload dots
// ----------------------------------------------------------------
always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        flash_cnt_reg   <= 36'h0;
        flash_reg       <= 1'b0;
        overload_dots_o <= 1'b0;
    end else begin
        if (flash_cnt_reg >= FLASH_CYC - 36'h1) begin
            flash_cnt_reg <= 36'h0;
            flash_reg     <= ~flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 36'h1;
        end
        overload_dots_o <= motor_over_rated_i && flash_reg;
    end
end

// ----------------------------------------------------------------
// OK key hold detector
// ----------------------------------------------------------------
wire ok_done;

dfm_timer u_ok_timer (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .start_i (1'b0),
    .run_i   (ok_level),
    .limit_i (OK_HOLD_CYC),
    .done_o  (ok_done)
);

reg ok_seen_reg;

always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ok_seen_reg <= 1'b0;
        ok_hold_o   <= 1'b0;
    end else begin
        ok_seen_reg <= ok_done;
        ok_hold_o   <= ok_done && !ok_seen_reg;
    end
end

endmodule // dfm_fault_manager

/* verif/dfm_fault_manager_asserts.sv */
`timescale 1ns/1ps
module dfm_chk #(
    parameter CLK_HZ      = 1000,
    parameter LOCK_BASE_S = 2
) (
    // Inputs
    input wire        clock_i,
    input wire        nrst_i,
    input wire        brake_current_trip_i,
    input wire        brake_resistor_overload_i,
    input wire        out_overcurrent_trip_i,
    input wire        motor_over_rated_i,
    input wire [1:0]  chopper_sel_i,
    input wire [15:0] access_entry_i,
    input wire [15:0] access_code_i,
    input wire        relay_on_fault_i,
    // Outputs
    input wire [7:0]  fault_code_o,
    input wire        fault_active_o,
    input wire        run_relay_o,
    input wire        stop_ready_indication_o,
    input wire [1:0]  log_index_o,
    input wire [3:0]  log_dots_o,
    input wire        log_view_active_o,
    input wire        overload_dots_o,
    input wire        ok_hold_o
);
    localparam int LOCK_CYC = LOCK_BASE_S * CLK_HZ;
    reg [31:0] held_reg;
    reg [2:0]  ltrip_reg;
    wire [35:0] lock_min = LOCK_CYC << (ltrip_reg - 3'h1);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // ------------------------------
    // Cycles the fault has stood
    // ------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            held_reg <= 32'h0;
        else if (!fault_active_o)
            held_reg <= 32'h0;
        else
            held_reg <= held_reg + 32'h1;
    end

    // Lockout-class trips seen, saturating at six
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            ltrip_reg <= 3'h0;
        else if (fault_active_o && held_reg == 32'h0 && ltrip_reg != 3'h6
                 && (fault_code_o == 8'h03 || fault_code_o == 8'h04))
            ltrip_reg <= ltrip_reg + 3'h1;
    end

    sequence s_oc_trip;
        out_overcurrent_trip_i && !brake_current_trip_i
            && !brake_resistor_overload_i && !fault_active_o;
    endsequence
    sequence s_oc_shown;
        fault_active_o && fault_code_o == 8'h03;
    endsequence

    oc_code_a: assert property (s_oc_trip |=> s_oc_shown)
        else $error("overcurrent code missing");
    relay_open_a: assert property (s_oc_trip ##1 relay_on_fault_i |=> !run_relay_o)
        else $error("relay closed on fault");
    ready_off_a: assert property (
        fault_active_o && $past(fault_active_o) |-> !stop_ready_indication_o)
        else $error("ready shown with fault");
    res_gate_a: assert property (
        $rose(fault_active_o) && fault_code_o == 8'h02 |-> $past(chopper_sel_i) == 2'h1)
        else $error("resistor fault without chopper");
    view_lock_a: assert property (
        (access_entry_i != access_code_i)[*3] |-> !log_view_active_o)
        else $error("log open while locked");
    dots_pos_a: assert property (
        log_dots_o != 4'h0 && $past(log_index_o) == log_index_o
            && $past(log_index_o, 2) == log_index_o
        |-> log_dots_o == (4'hf >> (2'h3 - log_index_o)))
        else $error("dots do not match index");
    ovl_dots_a: assert property ((!motor_over_rated_i)[*3] |-> !overload_dots_o)
        else $error("overload dots without overload");
    ok_pulse_a: assert property (ok_hold_o |=> !ok_hold_o)
        else $error("hold pulse too long");
    lock_hold_a: assert property (
        $fell(fault_active_o) && $past(fault_code_o) inside {8'h03, 8'h04}
        |-> held_reg >= lock_min - 36'h2)
        else $error("lockout fault cleared early");
endmodule // dfm_chk

/* verif/dfm_oper_model.sv */
`timescale 1ns/1ps
module dfm_oper_model (
    // Clock
    input  wire clock_i,
    // Keypad and fieldbus
    output reg  stop_key_o,
    output reg  up_key_o,
    output reg  ok_key_o,
    output reg  bus_reset_bit_o
);
    initial {stop_key_o, up_key_o, ok_key_o, bus_reset_bit_o} = 4'h0;

    // Key press or reset bit write, n cycles long
    task press(input int k, input int n);
        @(negedge clock_i);
        case (k)
            0: stop_key_o = 1'b1;
            1: up_key_o = 1'b1;
            2: ok_key_o = 1'b1;
            default: bus_reset_bit_o = 1'b1;
        endcase
        repeat (n) @(negedge clock_i);
        {stop_key_o, up_key_o, ok_key_o, bus_reset_bit_o} = 4'h0;
    endtask
endmodule // dfm_oper_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    reg         clock_i = 1'b0;
    reg         nrst_i  = 1'b0;
    reg         fwd, rev, bc, br, oc, mo, rof, drs, lv;
    reg  [1:0]  chop;
    reg  [15:0] aent, acod;
    wire        stp, up, ok, busr, act, rly, rdy, lva, odots, okh, mtrip;
    wire [7:0]  code, lent;
    wire [1:0]  lidx;
    wire [3:0]  ldots;
    int         err_count = 0;
    int         n_tests   = 0;
    int         cyc_n     = 0;

    always #5 clock_i = ~clock_i;

    dfm_fault_manager #(.CLK_HZ(1000), .OVL_CYCLES(20)) i_dut (
        .clock_i(clock_i), .nrst_i(nrst_i),
        .forward_enable_input_i(fwd), .reverse_enable_input_i(rev),
        .stop_key_i(stp), .up_key_i(up), .ok_key_i(ok),
        .brake_current_trip_i(bc), .brake_resistor_overload_i(br),
        .out_overcurrent_trip_i(oc), .motor_over_rated_i(mo),
        .chopper_sel_i(chop), .access_entry_i(aent), .access_code_i(acod),
        .relay_on_fault_i(rof), .defaults_restore_i(drs), .fault_log_view_i(lv),
        .bus_reset_bit_i(busr), .fault_code_o(code), .fault_active_o(act),
        .run_relay_o(rly), .stop_ready_indication_o(rdy), .log_entry_o(lent),
        .log_index_o(lidx), .log_dots_o(ldots), .log_view_active_o(lva),
        .overload_dots_o(odots), .ok_hold_o(okh), .motor_overload_trip_o(mtrip));

    dfm_oper_model i_op (.clock_i(clock_i), .stop_key_o(stp), .up_key_o(up),
        .ok_key_o(ok), .bus_reset_bit_o(busr));

    task chk(input logic [7:0] a, input logic [7:0] e);
        n_tests++;
        if (a !== e) begin
            err_count++;
            $display("mismatch %0t got %h exp %h", $time, a, e);
        end
    endtask
    task chb(input logic a, input logic e);
        chk({7'h0, a}, {7'h0, e});
    endtask
    task w(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task test_done;
        if (err_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task t_oc;
        fwd = 1'b1;
        w(8);
        chk({5'h0, act, rly, rdy}, 8'h02);
        oc = 1'b1;
        w(1);
        oc = 1'b0;
        w(2);
        chk(code, 8'h03);
        chb(rly, 1'b0);
        i_op.press(0, 3);
        w(1000);
        chb(act, 1'b1);
        w(1100);
        i_op.press(0, 3);
        w(6);
        chk({6'h0, act, rly}, 8'h01);
        fwd = 1'b0;
        w(6);
        chb(rdy, 1'b1);
    endtask
    task t_res;
        rof = 1'b0;
        fwd = 1'b1;
        chop = 2'h2;
        br = 1'b1;
        w(8);
        chb(act, 1'b0);
        chop = 2'h1;
        w(3);
        chk(code, 8'h02);
        chb(rly, 1'b1);
        rof = 1'b1;
        w(2);
        chb(rly, 1'b0);
        br = 1'b0;
        i_op.press(3, 2);
        w(6);
        chb(act, 1'b0);
        fwd = 1'b0;
        w(4);
    endtask
    task t_bc(input bit r);
        bc = 1'b1;
        w(1);
        bc = 1'b0;
        w(2);
        chk(code, 8'h01);
        {fwd, rev} = r ? 2'h1 : 2'h2;
        w(8);
        chb(act, 1'b0);
        {fwd, rev} = 2'h0;
        w(4);
    endtask
    task t_ovl;
        logic s;
        s = 1'b0;
        mo = 1'b1;
        w(10);
        chb(mtrip, 1'b0);
        w(20);
        chk({7'h0, mtrip} + code, 8'h05);
        repeat (600) begin
            w(1);
            s |= odots;
        end
        chb(s, 1'b1);
        mo = 1'b0;
        w(2400);
        i_op.press(0, 3);
        w(6);
        chb(act, 1'b1);
        w(1100);
        i_op.press(0, 3);
        w(6);
        chb(act, 1'b0);
    endtask
    task t_log;
        int i;
        logic [7:0] e [4] = '{8'h01, 8'h04, 8'h01, 8'h02};
        logic [3:0] d;
        drs = 1'b1;
        w(2);
        drs = 1'b0;
        lv = 1'b1;
        aent = 16'h0064;
        w(4);
        chb(lva, 1'b0);
        aent = 16'h0065;
        w(4);
        chb(lva, 1'b1);
        for (i = 0; i < 5; i++) begin
            chk(lent, e[i > 3 ? 3 : i]);
            chk({6'h0, lidx}, i > 3 ? 8'h3 : 8'(i));
            i_op.press(1, 3);
            w(6);
        end
        d = 4'h0;
        repeat (300) begin
            w(1);
            d |= ldots;
        end
        chk({4'h0, d}, 8'h0f);
        lv = 1'b0;
    endtask
    task t_ok;
        int n;
        n = 0;
        fork
            i_op.press(2, 2100);
            repeat (2200) begin
                w(1);
                n += okh;
            end
        join
        chk(8'(n), 8'h01);
    endtask

    always @(posedge clock_i) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        {fwd, rev, bc, br, oc, mo, drs, lv} = 8'h0;
        rof = 1'b1;
        chop = 2'h1;
        aent = 16'h0;
        acod = 16'h0065;
        w(16);
        nrst_i = 1'b1;
        w(8);
        chk({5'h0, act, rly, rdy}, 8'h01);
        t_oc();
        t_res();
        t_bc(1'b0);
        t_ovl();
        t_bc(1'b1);
        t_log();
        t_ok();
        test_done();
    end
endmodule // tb

bind dfm_fault_manager dfm_chk #(.CLK_HZ(CLK_HZ), .LOCK_BASE_S(LOCK_BASE_S)) i_chk (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .brake_current_trip_i(brake_current_trip_i),
    .brake_resistor_overload_i(brake_resistor_overload_i),
    .out_overcurrent_trip_i(out_overcurrent_trip_i), .motor_over_rated_i(motor_over_rated_i),
    .chopper_sel_i(chopper_sel_i), .access_entry_i(access_entry_i),
    .access_code_i(access_code_i), .relay_on_fault_i(relay_on_fault_i),
    .fault_code_o(fault_code_o), .fault_active_o(fault_active_o), .run_relay_o(run_relay_o),
    .stop_ready_indication_o(stop_ready_indication_o), .log_index_o(log_index_o),
    .log_dots_o(log_dots_o), .log_view_active_o(log_view_active_o),
    .overload_dots_o(overload_dots_o), .ok_hold_o(ok_hold_o));
